// ### hw/wcp_host.sv
// host end: APB-controlled two-wire write master
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module wcp_host (
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  wcp_link_if.host         link
);
  typedef enum logic [2:0] {HS_IDLE, HS_START, HS_BIT, HS_ACK, HS_STOP} wcp_hst_t;
  typedef struct packed {
    logic [1:0]  sda_s;
    wcp_hst_t    st;
    logic [7:0]  cnt;
    logic [1:0]  ph;
    logic [2:0]  bit_n;
    logic [7:0]  tx;
    logic        do_start;
    logic        do_stop;
    logic        in_frame;
    logic        nack;
    logic        scl;
    logic        sda;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
  } wcp_host_t;
  wcp_host_t s_r;
  wcp_host_t s_nxt;
  logic tick;
  logic acc;

  always_comb begin
    s_nxt = s_r;
    s_nxt.sda_s = {s_r.sda_s[0], link.sda};
    tick = (s_r.cnt == '0);
    s_nxt.cnt = tick ? wcp_pkg::HALF_CNT - 8'h01 : s_r.cnt - 8'h01;  // see [R17]
    acc = psel && penable && !s_r.ready;
    s_nxt.ready = acc;
    s_nxt.err = 1'b0;
    s_nxt.rdata = '0;
    if (acc && pwrite && paddr == wcp_pkg::OFF_CTRL && s_r.st == HS_IDLE) begin
      s_nxt.tx = pwdata[7:0];  // see [R5] [R11]
      s_nxt.do_start = pwdata[wcp_pkg::CTRL_START] || !s_r.in_frame;
      s_nxt.do_stop = pwdata[wcp_pkg::CTRL_STOP];
      if (pwdata[wcp_pkg::CTRL_GO]) begin
        s_nxt.st = HS_START;
        s_nxt.ph = '0;
        s_nxt.nack = 1'b0;
        s_nxt.cnt = wcp_pkg::HALF_CNT - 8'h01;
      end
    end else if (acc && !pwrite && paddr == wcp_pkg::OFF_STAT) begin
      s_nxt.rdata[wcp_pkg::STAT_BUSY] = (s_r.st != HS_IDLE);
      s_nxt.rdata[wcp_pkg::STAT_NACK] = s_r.nack;
    end else if (acc && paddr != wcp_pkg::OFF_CTRL && paddr != wcp_pkg::OFF_STAT) begin
      s_nxt.err = 1'b1;
    end
    if (tick) begin
      unique case (s_r.st)
        HS_IDLE: begin
          s_nxt.sda = 1'b1;  // see [R16]
        end
        HS_START: begin
          if (!s_r.do_start) begin
            s_nxt.st = HS_BIT;
            s_nxt.bit_n = '0;
            s_nxt.ph = '0;
          end else begin
            s_nxt.ph = s_r.ph + 2'h1;
            unique case (s_r.ph)
              2'h0: s_nxt.sda = 1'b1;
              2'h1: s_nxt.scl = 1'b1;
              2'h2: s_nxt.sda = 1'b0;  // see [R3]
              2'h3: begin
                s_nxt.scl = 1'b0;
                s_nxt.in_frame = 1'b1;
                s_nxt.st = HS_BIT;
                s_nxt.bit_n = '0;
                s_nxt.ph = '0;
              end
            endcase
          end
        end
        HS_BIT: begin
          s_nxt.ph = s_r.ph + 2'h1;
          unique case (s_r.ph)
            2'h0: s_nxt.sda = s_r.tx[7];  // see [R7] [R12]
            2'h1: s_nxt.scl = 1'b1;
            2'h2: s_nxt.scl = 1'b0;
            2'h3: begin
              s_nxt.tx = {s_r.tx[6:0], 1'b0};
              s_nxt.bit_n = s_r.bit_n + 3'h1;
              s_nxt.ph = '0;
              if (s_r.bit_n == wcp_pkg::BIT_LAST) begin
                s_nxt.st = HS_ACK;
              end
            end
          endcase
        end
        HS_ACK: begin
          s_nxt.ph = s_r.ph + 2'h1;
          unique case (s_r.ph)
            2'h0: s_nxt.sda = 1'b1;  // see [R8]
            2'h1: s_nxt.scl = 1'b1;
            2'h2: begin
              s_nxt.nack = s_r.sda_s[1];  // see [R13]
              s_nxt.scl = 1'b0;
            end
            2'h3: begin
              s_nxt.ph = '0;
              // see [R10]
              s_nxt.st = (s_r.nack || s_r.do_stop) ? HS_STOP : HS_IDLE;
            end
          endcase
        end
        HS_STOP: begin
          s_nxt.ph = s_r.ph + 2'h1;
          unique case (s_r.ph)
            2'h0: s_nxt.sda = 1'b0;
            2'h1: s_nxt.scl = 1'b1;
            2'h2: s_nxt.sda = 1'b1;  // see [R15]
            2'h3: begin
              s_nxt.in_frame = 1'b0;
              s_nxt.st = HS_IDLE;
              s_nxt.ph = '0;
            end
          endcase
        end
        default: s_nxt.st = HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{sda_s: 2'h3, st: HS_IDLE, scl: 1'b1, sda: 1'b1, default: '0};
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.rdata;
  assign pready = s_r.ready;
  assign pslverr = s_r.err;
  assign link.scl_o = s_r.scl;
  assign link.scl_oe = 1'b1;
  assign link.sda_m_o = 1'b0;
  assign link.sda_m_oe = !s_r.sda;
endmodule

// ### inc/wcp_pkg.sv
// package: constants for the two-wire write control port
package wcp_pkg;
  localparam logic [5:0] ADDR_FIXED   = 6'h3E;
  localparam int         BYTE_BITS    = 8;
  localparam logic [2:0] BIT_LAST     = 3'h7;
  localparam logic [1:0] SEL_MONO     = 2'h0;
  localparam logic [1:0] SEL_LEFT     = 2'h1;
  localparam logic [1:0] SEL_RIGHT    = 2'h2;
  localparam logic [1:0] SEL_CONFIG   = 2'h3;
  localparam int         SEL_HI       = 7;
  localparam int         SEL_LO       = 6;
  localparam int         MONO_W       = 5;
  localparam int         FIELD_W      = 6;
  localparam logic [4:0] GAIN_0DB     = 5'h1B;
  localparam logic [4:0] GAIN_M6DB    = 5'h17;
  localparam int         PCLK_HZ      = 40000000;
  localparam int         SCL_MAX_HZ   = 400000;
  localparam int         HALF_CYC     = (PCLK_HZ + 2 * SCL_MAX_HZ - 1) / (2 * SCL_MAX_HZ);
  localparam logic [7:0] HALF_CNT     = 8'(HALF_CYC);
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STAT     = 8'h04;
  localparam int         CTRL_GO      = 8;
  localparam int         CTRL_STOP    = 9;
  localparam int         CTRL_START   = 10;
  localparam int         STAT_BUSY    = 0;
  localparam int         STAT_NACK    = 1;
endpackage

// ### inc/wcp_link_if.sv
// interface: two-wire link between host master and device slave
`timescale 1ns/100ps
interface wcp_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  wire  scl = scl_oe ? scl_o : 1'b1;
  wire  sda = (sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o) ? 1'b0 : 1'b1;
  modport host (output scl_o, scl_oe, sda_m_o, sda_m_oe, input sda);
  modport device (output sda_s_o, sda_s_oe, input scl, sda);
endinterface

// ### hw/wcp_device.sv
// device end: write-only two-wire slave with four setting registers
`timescale 1ns/100ps
// Functional notes
// [R1] address is 111110 plus select pin bit
// [R2] select pin high gives bit one
// [R3] start is data falling while clock high
// [R4] compare address byte after start
// [R5] master sends address byte msb first
// [R6] sample bits on clock rising edge
// [R7] master holds address bit while clock high
// [R8] master releases data for acknowledge pulse
// [R9] pull data low on own address
// [R10] master abandons on missing address acknowledge
// [R11] master sends data bytes msb first
// [R12] master holds data bit while clock high
// [R13] acknowledge each data byte low
// [R14] accept any number of data bytes
// [R15] stop is data rising while clock high
// [R16] master leaves data high when idle
// [R17] clock no faster than 400 kHz
// [R18] codes 11011 0 dB, 10111 minus 6 dB
// [R19] host lowers volume 6 dB on 3D; wcp_host only sends the bytes written to CTRL and never changes a gain code
// [R20] upper bits pick one of four registers
// [R21] drive data only during acknowledge
module wcp_device (
  // clock, reset, enable
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clk_en,
  // address select pin
  input  wire logic       addr_sel,
  // link
  wcp_link_if.device      link,
  // settings
  output logic [4:0]      mono_gain_code,
  output logic [5:0]      left_gain_code,
  output logic [5:0]      right_gain_code,
  output logic [5:0]      output_config_code,
  output logic            gain_is_0db,
  output logic            gain_is_m6db
);
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_ACK} wcp_dst_t;
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [1:0] sel_s;
    logic       scl_d;
    logic       sda_d;
    wcp_dst_t   st;
    logic       addr_ph;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic       ack_drv;
    logic [4:0] mono;
    logic [5:0] left;
    logic [5:0] right;
    logic [5:0] cfg;
    logic       is0;
    logic       ism6;
  } wcp_dev_t;
  wcp_dev_t s_r;
  wcp_dev_t s_nxt;
  logic scl_rise;
  logic scl_fall;
  logic [7:0] rx_byte;

  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_s = {s_r.scl_s[0], link.scl};
    s_nxt.sda_s = {s_r.sda_s[0], link.sda};
    s_nxt.sel_s = {s_r.sel_s[0], addr_sel};
    s_nxt.scl_d = s_r.scl_s[1];
    s_nxt.sda_d = s_r.sda_s[1];
    scl_rise = s_r.scl_s[1] && !s_r.scl_d;
    scl_fall = !s_r.scl_s[1] && s_r.scl_d;
    rx_byte = {s_r.shift[6:0], s_r.sda_s[1]};
    s_nxt.is0 = (s_r.left[4:0] == wcp_pkg::GAIN_0DB);  // see [R18]
    s_nxt.ism6 = (s_r.left[4:0] == wcp_pkg::GAIN_M6DB);  // see [R18]
    if (s_r.scl_s[1] && s_r.scl_d && s_r.sda_d && !s_r.sda_s[1]) begin
      s_nxt.st = ST_ADDR;  // see [R3]
      s_nxt.addr_ph = 1'b1;
      s_nxt.bit_cnt = '0;
      s_nxt.ack_drv = 1'b0;
    end else if (s_r.scl_s[1] && s_r.scl_d && !s_r.sda_d && s_r.sda_s[1]) begin
      s_nxt.st = ST_IDLE;  // see [R15]
      s_nxt.ack_drv = 1'b0;
    end else begin
      unique case (s_r.st)
        ST_IDLE: begin
          s_nxt.ack_drv = 1'b0;
        end
        ST_ADDR, ST_DATA: begin
          if (scl_rise) begin
            s_nxt.shift = rx_byte;  // see [R6]
            s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
            if (s_r.bit_cnt == wcp_pkg::BIT_LAST) begin
              s_nxt.st = ST_ACK;
              if (s_r.st == ST_ADDR) begin
                // see [R1] [R2] [R4]
                s_nxt.addr_ph = (rx_byte[7:1] == {wcp_pkg::ADDR_FIXED, s_r.sel_s[1]}) && !rx_byte[0];
                if (!s_nxt.addr_ph) begin
                  s_nxt.st = ST_IDLE;
                end
              end else begin
                s_nxt.addr_ph = 1'b0;
                unique case (rx_byte[wcp_pkg::SEL_HI:wcp_pkg::SEL_LO])  // see [R20]
                  wcp_pkg::SEL_MONO:   s_nxt.mono = rx_byte[wcp_pkg::MONO_W-1:0];
                  wcp_pkg::SEL_LEFT:   s_nxt.left = rx_byte[wcp_pkg::FIELD_W-1:0];
                  wcp_pkg::SEL_RIGHT:  s_nxt.right = rx_byte[wcp_pkg::FIELD_W-1:0];
                  wcp_pkg::SEL_CONFIG: s_nxt.cfg = rx_byte[wcp_pkg::FIELD_W-1:0];
                endcase
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall && !s_r.ack_drv) begin
            // see [R9] [R13] [R21]
            s_nxt.ack_drv = 1'b1;
          end else if (scl_fall && s_r.ack_drv) begin
            s_nxt.ack_drv = 1'b0;
            s_nxt.st = ST_DATA;  // see [R14]
            s_nxt.addr_ph = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{scl_s: 2'h3, sda_s: 2'h3, scl_d: 1'b1, sda_d: 1'b1, st: ST_IDLE, default: '0};
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign link.sda_s_o = 1'b0;
  assign link.sda_s_oe = s_r.ack_drv;
  assign mono_gain_code = s_r.mono;
  assign left_gain_code = s_r.left;
  assign right_gain_code = s_r.right;
  assign output_config_code = s_r.cfg;
  assign gain_is_0db = s_r.is0;
  assign gain_is_m6db = s_r.ism6;
endmodule

// ### verif/wcp_link_asserts.sv
// checker: drive and timing relations on the two-wire link
`timescale 1ns/100ps
module wcp_link_asserts (
  // clock, reset
  input wire logic pclk,
  input wire logic presetn,
  // link drivers and wires
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_r;
  logic [7:0] per_r;
  // cycles since last clock rise, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_r <= 1'h1;
      per_r <= 8'hFF;
    end else begin
      scl_r <= scl;
      per_r <= (scl && !scl_r) ? 8'h01 : per_r + {7'h0, per_r != 8'hFF};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence start_s;
    $fell(sda) && scl;
  endsequence
  sequence stop_s;
    $rose(sda) && scl;
  endsequence
  a_host_open_drain: assert property (sda_m_oe |-> !sda_m_o) else $error("host drives data high");
  a_dev_open_drain: assert property (sda_s_oe |-> !sda_s_o) else $error("device drives data high");
  a_dev_on_low: assert property ($rose(sda_s_oe) |-> !scl) else $error("device grabs data, clock high");
  a_dev_off_low: assert property ($fell(sda_s_oe) |-> !scl) else $error("device drops data, clock high");
  a_ack_holds_high: assert property ($rose(scl) && sda_s_oe |-> sda_s_oe [*8]) else $error("ack cut short");
  a_ack_released: assert property (sda_s_oe |-> ##[1:400] !sda_s_oe) else $error("ack held too long");
  a_scl_max_rate: assert property ($rose(scl) |-> per_r >= 8'h64) else $error("clock too fast");
  a_start_holds: assert property (start_s |-> scl [*4]) else $error("start not held");
  a_stop_idle: assert property (stop_s |-> sda [*8]) else $error("data not high after stop");
endmodule

// ### verif/wcp_tb_top.sv
// testbench: host and device joined over the two-wire link
`timescale 1ns/100ps
module wcp_tb_top;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic        addr_sel = 1'h0;
  logic        scl_q = 1'h1;
  logic        pready, pslverr, err, is0, is6;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic [8:0]  sh = 9'h000;
  logic [4:0]  mono;
  logic [5:0]  left, right, cfg;
  int          bad_count = 0;
  int          samples_checked = 0;
  always #12.5 pclk = ~pclk;
  wcp_link_if link ();
  wcp_host u_wcp_host (.pclk(pclk), .presetn(presetn), .clk_en(1'h1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link));
  wcp_device u_wcp_device (.pclk(pclk), .presetn(presetn), .clk_en(1'h1), .addr_sel(addr_sel), .link(link),
    .mono_gain_code(mono), .left_gain_code(left), .right_gain_code(right), .output_config_code(cfg),
    .gain_is_0db(is0), .gain_is_m6db(is6));
  wcp_link_asserts u_wcp_link_asserts (.pclk(pclk), .presetn(presetn), .sda_m_o(link.sda_m_o),
    .sda_m_oe(link.sda_m_oe), .sda_s_o(link.sda_s_o), .sda_s_oe(link.sda_s_oe), .scl(link.scl), .sda(link.sda));
  // wire bits seen at each clock rise
  always @(posedge pclk) begin
    scl_q <= link.scl;
    if (link.scl && !scl_q) sh <= {sh[7:0], link.sda};
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(negedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task send(input logic [7:0] b, input logic st, input logic sp);
    apb(1'h1, wcp_pkg::OFF_CTRL, {21'h0, st, sp, 1'h1, b});
    do apb(1'h0, wcp_pkg::OFF_STAT, 32'h0); while (rd[wcp_pkg::STAT_BUSY] === 1'h1);
    chk({rd[1], sh}, {1'h0, sp ? {b[6:0], 2'h0} : {b, 1'h0}});
  endtask
  task t_reset;
    chk({9'h0, mono, left, right, cfg}, 32'h0);
    chk({link.scl, link.sda}, 2'h3);
    $display("test reset done");
  endtask
  task t_frame(input logic s, input logic [5:0] lg);
    addr_sel <= s;
    send({6'h3E, s, 1'h0}, 1'h1, 1'h0);
    send({2'h1, lg}, 1'h0, 1'h0);
    send(8'hAA, 1'h0, 1'h0);
    send(8'hD5, 1'h0, 1'h0);
    send(8'h17, 1'h0, 1'h1);
    chk({9'h0, mono, left, right, cfg}, {9'h0, 5'h17, lg, 6'h2A, 6'h15});
    chk({is0, is6}, {lg[4:0] === 5'h1B, lg[4:0] === 5'h17});
    $display("test frame done");
  endtask
  task t_refuse;
    addr_sel <= 1'h1;
    apb(1'h1, wcp_pkg::OFF_CTRL, {21'h0, 3'h3, 6'h3E, 2'h0});
    do apb(1'h0, wcp_pkg::OFF_STAT, 32'h0); while (rd[wcp_pkg::STAT_BUSY] === 1'h1);
    chk({rd[1], sh[1]}, 2'h3);
    apb(1'h1, wcp_pkg::OFF_CTRL, {21'h0, 3'h3, 6'h3E, 2'h3});
    do apb(1'h0, wcp_pkg::OFF_STAT, 32'h0); while (rd[wcp_pkg::STAT_BUSY] === 1'h1);
    chk({rd[1], sh[1]}, 2'h3);
    chk({9'h0, mono, left, right, cfg}, {9'h0, 5'h17, 6'h17, 6'h2A, 6'h15});
    $display("test refuse done");
  endtask
  task t_badreg;
    apb(1'h0, 8'h08, 32'h0);
    chk(err, 1'h1);
    $display("test unmapped done");
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset;
    t_frame(1'h0, 6'h1B);
    t_frame(1'h1, 6'h17);
    t_refuse;
    t_badreg;
    end_of_test;
  end
  // watchdog
  initial begin
    repeat (90000) @(posedge pclk);
    bad_count++;
    end_of_test;
  end
endmodule
